/* hw/prm_port_route_match.sv */
// top: routing configuration register and port match logic
`timescale 1ns/1ns
module prm_port_route_match
  import prm_pkg::*;
(
  input wire logic clk, // 100 MHz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire prm_sfr_s sfr, // register access request
  output logic [7:0] sfr_rdata_q, // read data, one cycle after rd
  output logic sfr_rvalid_q, // read data valid pulse
  input wire logic [7:0] port0_pins, // port 0 input levels
  input wire logic [7:0] port1_pins, // port 1 input levels
  input wire logic [7:0] port0_analog, // 1 = port 0 pin in analog mode
  input wire logic [7:0] port1_analog, // 1 = port 1 pin in analog mode
  output prm_route_s route_q, // decoded routing to crossbar
  output logic [7:0] port0_pullup_en_q, // per-pin weak pullup enable
  output logic [7:0] port1_pullup_en_q, // per-pin weak pullup enable
  output logic mismatch_irq_q, // mismatch interrupt request level
  output logic mismatch_wake_q // mismatch wake-up level
);

  //////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] route_reg_q;
  logic [7:0] p0_mask_q;
  logic [7:0] p1_mask_q;
  logic [7:0] p0_exp_q;
  logic [7:0] p1_exp_q;
  logic sel_route;
  logic sel_p0_mask;
  logic sel_p0_exp;
  logic sel_p1_mask;
  logic sel_p1_exp;

  // 0xe2 is shared by two pages; the page selects which register answers
  assign sel_route = (sfr.page == PRM_PAGE_ROUTE) && (sfr.addr == PRM_ROUTE_ADDR);
  assign sel_p0_mask = (sfr.page == PRM_PAGE_MATCH) && (sfr.addr == PRM_P0_MASK_ADDR);
  assign sel_p0_exp = (sfr.page == PRM_PAGE_MATCH) && (sfr.addr == PRM_P0_EXP_ADDR);
  assign sel_p1_mask = (sfr.page == PRM_PAGE_MATCH) && (sfr.addr == PRM_P1_MASK_ADDR);
  assign sel_p1_exp = (sfr.page == PRM_PAGE_MATCH) && (sfr.addr == PRM_P1_EXP_ADDR);

  // one write strobe per register; an unmapped write raises none and is dropped
  logic wr_route;
  logic wr_p0_mask;
  logic wr_p1_mask;
  logic wr_p0_exp;
  logic wr_p1_exp;

  assign wr_route = sfr.wr && sel_route;
  assign wr_p0_mask = sfr.wr && sel_p0_mask;
  assign wr_p1_mask = sfr.wr && sel_p1_mask;
  assign wr_p0_exp = sfr.wr && sel_p0_exp;
  assign wr_p1_exp = sfr.wr && sel_p1_exp;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      route_reg_q <= PRM_ROUTE_RST;
    end else if (wr_route) begin
      route_reg_q <= sfr.wdata & PRM_ROUTE_WMASK;
    end
  end

  // compare masks: a cleared bit takes its pin out of the match
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p0_mask_q <= PRM_MASK_RST;
    end else if (wr_p0_mask) begin
      p0_mask_q <= sfr.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p1_mask_q <= PRM_MASK_RST;
    end else if (wr_p1_mask) begin
      p1_mask_q <= sfr.wdata;
    end
  end

  // expected levels reset to all ones, the idle level of pulled-up pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p0_exp_q <= PRM_EXP_RST;
    end else if (wr_p0_exp) begin
      p0_exp_q <= sfr.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p1_exp_q <= PRM_EXP_RST;
    end else if (wr_p1_exp) begin
      p1_exp_q <= sfr.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path; unmapped addresses answer zero
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00_00;
    if (sel_route) begin
      rdata_d = route_reg_q;
    end else if (sel_p0_mask) begin
      rdata_d = p0_mask_q;
    end else if (sel_p1_mask) begin
      rdata_d = p1_mask_q;
    end else if (sel_p0_exp) begin
      rdata_d = p0_exp_q;
    end else if (sel_p1_exp) begin
      rdata_d = p1_exp_q;
    end
  end

  // data is zero outside a read so an idle bus never shows stale contents
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfr_rdata_q <= 8'h00_00;
    end else begin
      sfr_rdata_q <= sfr.rd ? rdata_d : 8'h00_00;
    end
  end

  // one-cycle pulse in the cycle the read data stands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfr_rvalid_q <= 1'b0;
    end else begin
      sfr_rvalid_q <= sfr.rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // routing decode, registered so outputs come from flip-flops
  logic [2:0] mod_d;

  always_comb begin
    case (route_reg_q[PRM_MOD_LSB +: 2])
      2'b00: mod_d = 3'b000;
      2'b01: mod_d = 3'b001;
      2'b10: mod_d = 3'b011;
      2'b11: mod_d = 3'b111;
      default: mod_d = 3'b000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      route_q <= '0;
    end else begin
      route_q.pullup_on <= ~route_reg_q[PRM_PUD_BIT];
      route_q.crossbar_on <= route_reg_q[PRM_XBAR_BIT];
      // while the crossbar is off nothing is handed to peripherals or drivers
      route_q.timer1_input_route <= route_reg_q[PRM_XBAR_BIT] & route_reg_q[PRM_T1_BIT];
      route_q.timer0_input_route <= route_reg_q[PRM_XBAR_BIT] & route_reg_q[PRM_T0_BIT];
      route_q.ext_count_clock_route <= route_reg_q[PRM_XBAR_BIT] & route_reg_q[PRM_ECI_BIT];
      route_q.module_io_route <= route_reg_q[PRM_XBAR_BIT] ? mod_d : 3'b000;
    end
  end

  // analog pins never get a pullup regardless of the disable bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port0_pullup_en_q <= 8'h00_00;
      port1_pullup_en_q <= 8'h00_00;
    end else begin
      port0_pullup_en_q <= route_reg_q[PRM_PUD_BIT] ? 8'h00_00 : ~port0_analog;
      port1_pullup_en_q <= route_reg_q[PRM_PUD_BIT] ? 8'h00_00 : ~port1_analog;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port match: raw pins, crossbar settings play no part
  logic p0_miss;
  logic p1_miss;

  prm_port_cmp u_cmp0 (
    .pins(port0_pins),
    .mask(p0_mask_q),
    .expected(p0_exp_q),
    .mismatch(p0_miss)
  );

  prm_port_cmp u_cmp1 (
    .pins(port1_pins),
    .mask(p1_mask_q),
    .expected(p1_exp_q),
    .mismatch(p1_miss)
  );

  // level output, not sticky: the interrupt and power logic outside latch it as they need
  logic any_miss;

  assign any_miss = p0_miss | p1_miss;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mismatch_irq_q <= 1'b0;
    end else begin
      mismatch_irq_q <= any_miss;
    end
  end

  // its own flop so the wake path can be placed apart from the interrupt path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mismatch_wake_q <= 1'b0;
    end else begin
      mismatch_wake_q <= any_miss;
    end
  end

endmodule

/* hw/prm_pkg.sv */
// package: register map, field positions and reset values for port routing and match
package prm_pkg;
  // special function register addresses (page F for routing, page 0 for match)
  localparam logic [7:0] PRM_ROUTE_ADDR = 8'h00_e2;
  localparam logic [7:0] PRM_P0_MASK_ADDR = 8'h00_f4;
  localparam logic [7:0] PRM_P0_EXP_ADDR = 8'h00_f3;
  localparam logic [7:0] PRM_P1_MASK_ADDR = 8'h00_e2;
  localparam logic [7:0] PRM_P1_EXP_ADDR = 8'h00_e1;
  localparam logic [7:0] PRM_PAGE_ROUTE = 8'h00_0f;
  localparam logic [7:0] PRM_PAGE_MATCH = 8'h00_00;

  // routing register fields
  localparam int PRM_PUD_BIT = 7;
  localparam int PRM_XBAR_BIT = 6;
  localparam int PRM_T1_BIT = 5;
  localparam int PRM_T0_BIT = 4;
  localparam int PRM_ECI_BIT = 3;
  localparam int PRM_MOD_LSB = 0;
  localparam logic [7:0] PRM_ROUTE_WMASK = 8'h00_fb;

  // reset values
  localparam logic [7:0] PRM_ROUTE_RST = 8'h00_00;
  localparam logic [7:0] PRM_MASK_RST = 8'h00_00;
  localparam logic [7:0] PRM_EXP_RST = 8'h00_ff;

  // special function register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prm_sfr_s;

  // decoded routing towards the crossbar
  typedef struct packed {
    logic pullup_on;
    logic crossbar_on;
    logic timer1_input_route;
    logic timer0_input_route;
    logic ext_count_clock_route;
    logic [2:0] module_io_route;
  } prm_route_s;
endpackage

/* hw/prm_port_cmp.sv */
// one port's masked compare against its expected value
`timescale 1ns/1ns
module prm_port_cmp
  import prm_pkg::*;
#(
  parameter int WIDTH = 8 // pins per port
)
(
  input wire logic [WIDTH-1:0] pins, // live pin levels
  input wire logic [WIDTH-1:0] mask, // compare select
  input wire logic [WIDTH-1:0] expected, // expected levels
  output logic mismatch // masked levels differ
);
  assign mismatch = ((pins & mask) != (expected & mask));
endmodule

/* verification/prm_checker.sv */
// assertion checker for the port routing and match block
`timescale 1ns/1ns
module prm_checker
  import prm_pkg::*;
(
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire prm_sfr_s sfr, // access
  input wire logic [7:0] sfr_rdata_q, // read data
  input wire logic sfr_rvalid_q, // read valid
  input wire logic [7:0] port0_pins, // pins
  input wire logic [7:0] port1_pins, // pins
  input wire logic [7:0] port0_analog, // analog
  input wire logic [7:0] port1_analog, // analog
  input wire prm_route_s route_q, // routing
  input wire logic [7:0] port0_pullup_en_q, // pullups
  input wire logic [7:0] port1_pullup_en_q, // pullups
  input wire logic mismatch_irq_q, // event
  input wire logic mismatch_wake_q // wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  chk_read_pulse: assert property (sfr.rd |=> sfr_rvalid_q) else $error("no read valid");
  chk_pullup_off: assert property (!route_q.pullup_on |-> {port1_pullup_en_q, port0_pullup_en_q} == 16'h0000)
    else $error("pullup left on");
  chk_pullup_analog: assert property (route_q.pullup_on |-> port0_pullup_en_q == ~$past(port0_analog)
    && port1_pullup_en_q == ~$past(port1_analog)) else $error("pullup wrong");
  chk_xbar_gate: assert property (!route_q.crossbar_on |-> route_q[5:0] == 6'h00) else $error("route leak");
  chk_mod_therm: assert property (route_q.module_io_route inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("module route code");
  chk_irq_wake: assert property (mismatch_irq_q == mismatch_wake_q) else $error("wake differs");
  // with registers and pins frozen the event cannot move
  chk_match_stable: assert property (!sfr.wr ##1 ($stable(port0_pins) && $stable(port1_pins))
    |=> $stable(mismatch_irq_q)) else $error("event moved");
  chk_bit2_zero: assert property (sfr.rd && sfr.page == PRM_PAGE_ROUTE && sfr.addr == PRM_ROUTE_ADDR
    |=> !sfr_rdata_q[2]) else $error("bit 2 read back");
endmodule

bind prm_port_route_match prm_checker u_prm_checker (.*);

/* verification/prm_pin_model.sv */
// model of the outside circuitry driving both ports
`timescale 1ns/1ns
module prm_pin_model (
  input wire logic clk, // clock
  input wire logic [15:0] want, // requested levels
  output logic [15:0] pins // port 1 and port 0 levels
);
  // a slow driver: levels settle one cycle after the request
  always_ff @(posedge clk) begin
    pins <= want;
  end
endmodule

/* verification/prm_port_route_match_tb_top.sv */
// self-checking bench for port routing and match
`timescale 1ns/1ns
module prm_port_route_match_tb_top import prm_pkg::*; ;
  logic clk = 0, sys_rst = 1, rvalid, irq, wake;
  prm_sfr_s sfr = '0;
  prm_route_s route;
  logic [7:0] rdata, a0 = 0, a1 = 0, pu0, pu1, r, exp_rd;
  logic [15:0] want = '1, pins, m, e, f;
  int n_fail = 0, checked = 0, seed = 32'h0000_a5ae;
  logic [7:0] expq[$];
`define CMP(a, x) begin checked++; if ((a) !== (x)) begin n_fail++; \
  $display("FAIL %0t got %h exp %h", $time, a, x); end end
  initial forever #5 clk = ~clk;
  prm_port_route_match u_prm_port_route_match (.clk(clk), .sys_rst(sys_rst), .sfr(sfr), .sfr_rdata_q(rdata),
    .sfr_rvalid_q(rvalid), .port0_pins(pins[7:0]), .port1_pins(pins[15:8]), .port0_analog(a0),
    .port1_analog(a1), .route_q(route), .port0_pullup_en_q(pu0), .port1_pullup_en_q(pu1),
    .mismatch_irq_q(irq), .mismatch_wake_q(wake));
  prm_pin_model u_prm_pin_model (.clk(clk), .want(want), .pins(pins));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic w, input logic [7:0] pg, ad, d);
    if (!w) expq.push_back(d);
    @(posedge clk);
    sfr <= '{w, !w, pg, ad, d};
    @(posedge clk);
    sfr <= '0;
  endtask
  task automatic final_report;
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) if (rvalid === 1'b1) begin
    exp_rd = expq.pop_front();
    `CMP(rdata, exp_rd)
  end
  initial begin
    #20000;
    n_fail++;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    a0 <= 8'($random(seed));
    a1 <= 8'($random(seed));
    acc(1, 8'h05, PRM_ROUTE_ADDR, 8'hff); // unmapped page write must touch neither shared register
    acc(0, PRM_PAGE_ROUTE, PRM_ROUTE_ADDR, PRM_ROUTE_RST);
    acc(0, PRM_PAGE_MATCH, PRM_P0_EXP_ADDR, PRM_EXP_RST);
    acc(0, PRM_PAGE_MATCH, PRM_P1_MASK_ADDR, PRM_MASK_RST);
    acc(0, 8'h00_05, 8'h00_e2, 8'h00_00); // unmapped page reads zero
    for (int i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      r[1:0] = i[1:0];
      r[6] = i[2];
      acc(1, PRM_PAGE_ROUTE, PRM_ROUTE_ADDR, r);
      acc(0, PRM_PAGE_ROUTE, PRM_ROUTE_ADDR, r & PRM_ROUTE_WMASK);
      `CMP(route, {~r[7], r[6], {3{r[6]}} & r[5:3], {3{r[6]}} & {&r[1:0], r[1], |r[1:0]}})
      `CMP({pu1, pu0}, r[7] ? 16'h0000 : ~{a1, a0})
    end
    // odd passes walk one masked flip over both ports, even passes flip only unmasked pins
    for (int i = 0; i < 16; i++) begin
      m = 16'($random(seed));
      e = 16'($random(seed));
      f = 16'($random(seed));
      f = i[0] ? 16'h0001 << i : f & ~m;
      if (i[0]) m = m | f;
      acc(1, PRM_PAGE_MATCH, PRM_P0_MASK_ADDR, m[7:0]);
      acc(1, PRM_PAGE_MATCH, PRM_P1_MASK_ADDR, m[15:8]);
      acc(1, PRM_PAGE_MATCH, PRM_P0_EXP_ADDR, e[7:0]);
      acc(1, PRM_PAGE_MATCH, PRM_P1_EXP_ADDR, e[15:8]);
      acc(1, PRM_PAGE_ROUTE, PRM_ROUTE_ADDR, 8'($random(seed)));
      acc(0, PRM_PAGE_MATCH, PRM_P1_MASK_ADDR, m[15:8]);
      want <= e ^ f;
      repeat (3) @(posedge clk);
      `CMP({irq, wake}, {2{|(f & m)}})
    end
    repeat (2) @(posedge clk);
    `CMP(expq.size(), 0)
    final_report;
  end
endmodule
